/* design/psr_top.sv */
// Protection signal routing: switch groups, relays, triggers and indicators
`timescale 1ns/10ps

// Summary of operation
// - Route switch bits 1-4 gate OV, UV, residual low, high trips to trip relay.
// - Route switch bits 5 and 6 gate OV and UV trips to shared alarm.
// - Route switch bit 7 gates the OV start to the shared alarm.
// - Route switch bit 8 gates the UV start to the UV alarm relay.
// - OV alarm follows OV stage; residual alarm follows residual low stage, fixed.
// - Residual options 1-3 route low/high starts onto recorder triggers two and three.
// - Residual options 4 and 5 let blocking input suppress low and high trips.
// - UV options 1-3 route OV/UV starts onto recorder triggers one and three.
// - UV option 5 lets blocking suppress the UV trip; bits 4,6,7,8 unused.
// - Stage indicator yellow while started, red once tripped.
// - Indicator self-reset or manual-reset; manual keeps red latched.
// - Local reset button clears latched red indicators.
// - Latched indicators never alter protection outputs.
// - Recorder indicator dark idle, green recording, red when stored.
// - Recorder red persists while any recording remains stored.
// - Self fault alarm on supply deviation, missing module or no auxiliary input.
// - Self fault indicator lights on a permanent internal fault.
// - Supply indicator lit while power supply operates.
// - Each scroll press advances the display index by one.
module psr_top (
   input  wire logic               pclk,
   input  wire logic               presetn,
   input  wire logic [7:0]         paddr,
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [31:0]        pwdata,
   output logic [31:0]             prdata,
   output logic                    pready,
   output logic                    pslverr,
   input  wire psr_pkg::psr_stage_t stage_in,
   input  wire logic               external_block_input,
   input  wire logic               reset_button,
   input  wire logic               scroll_button,
   input  wire logic               recording_active,
   input  wire logic               recording_stored,
   input  wire logic               supply_deviation,
   input  wire logic               supply_absent,
   input  wire logic               aux_input_lost,
   input  wire logic               permanent_fault,
   input  wire logic               supply_ok,
   output psr_pkg::psr_out_t       relays_ff,
   output psr_pkg::psr_led_t       stage_led [4],
   output psr_pkg::psr_led_t       recorder_led_ff,
   output logic                    self_fault_alarm_ff,
   output logic                    self_fault_led_ff,
   output logic                    supply_indicator_ff,
   output logic [2:0]              display_index_ff
);

   ////////////////////////////////////////////////////////////////////////////
   // Input synchronisers
   ////////////////////////////////////////////////////////////////////////////
   localparam int NSYNC = 18;

   logic [NSYNC-1:0] raw_in;
   logic [NSYNC-1:0] sync1_ff;
   logic [NSYNC-1:0] sync2_ff;

   assign raw_in = {stage_in, external_block_input, reset_button, scroll_button,
                    recording_active, recording_stored, supply_deviation,
                    supply_absent, aux_input_lost, permanent_fault, supply_ok};

   // Pins are asynchronous; first stage feeds only the second
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_ff <= '0;
         sync2_ff <= '0;
      end else begin
         sync1_ff <= raw_in;
         sync2_ff <= sync1_ff;
      end
   end

   psr_pkg::psr_stage_t s_stage;
   logic s_block;
   logic s_rst_btn;
   logic s_scroll;
   logic s_rec_act;
   logic s_rec_stored;
   logic s_dev;
   logic s_absent;
   logic s_aux_lost;
   logic s_perm;
   logic s_supply;

   assign {s_stage, s_block, s_rst_btn, s_scroll, s_rec_act, s_rec_stored,
           s_dev, s_absent, s_aux_lost, s_perm, s_supply} = sync2_ff;

   ////////////////////////////////////////////////////////////////////////////
   // APB registers
   ////////////////////////////////////////////////////////////////////////////
   logic [7:0] route_switch_ff;
   logic [7:0] uv_option_ff;
   logic [7:0] res_option_ff;
   logic [3:0] manual_mode_ff;
   logic       sw_clear;
   logic       wr_en;
   logic       addr_ok;

   assign wr_en   = psel && penable && pwrite;
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !addr_ok;

   // Address check for error response
   always_comb begin
      if (paddr == psr_pkg::ROUTE_SW_OFS) begin
         addr_ok = 1'b1;
      end else if (paddr == psr_pkg::UV_OPT_OFS) begin
         addr_ok = 1'b1;
      end else if (paddr == psr_pkg::RES_OPT_OFS) begin
         addr_ok = 1'b1;
      end else if (paddr == psr_pkg::CTRL_OFS) begin
         addr_ok = 1'b1;
      end else if (paddr == psr_pkg::STATUS_OFS) begin
         addr_ok = 1'b1;
      end else if (paddr == psr_pkg::DISP_OFS) begin
         addr_ok = 1'b1;
      end else begin
         addr_ok = 1'b0;
      end
   end

   // Switch group writes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         route_switch_ff <= psr_pkg::ROUTE_SW_RST;
         uv_option_ff    <= psr_pkg::UV_OPT_RST;
         res_option_ff   <= psr_pkg::RES_OPT_RST;
         manual_mode_ff  <= psr_pkg::CTRL_RST;
      end else if (wr_en) begin
         if (paddr == psr_pkg::ROUTE_SW_OFS) begin
            route_switch_ff <= pwdata[7:0];
         end else if (paddr == psr_pkg::UV_OPT_OFS) begin
            uv_option_ff <= pwdata[7:0];
         end else if (paddr == psr_pkg::RES_OPT_OFS) begin
            res_option_ff <= pwdata[7:0];
         end else if (paddr == psr_pkg::CTRL_OFS) begin
            manual_mode_ff <= pwdata[3:0];
         end
      end
   end

   // Software clear pulse: CTRL bit 8 written as one
   assign sw_clear = wr_en && (paddr == psr_pkg::CTRL_OFS) && pwdata[8];

   // Read mux, combinational from registered state
   always_comb begin
      prdata = 32'h0000_0000;
      if (paddr == psr_pkg::ROUTE_SW_OFS) begin
         prdata[7:0] = route_switch_ff;
      end else if (paddr == psr_pkg::UV_OPT_OFS) begin
         prdata[7:0] = uv_option_ff;
      end else if (paddr == psr_pkg::RES_OPT_OFS) begin
         prdata[7:0] = res_option_ff;
      end else if (paddr == psr_pkg::CTRL_OFS) begin
         prdata[3:0] = manual_mode_ff;
      end else if (paddr == psr_pkg::STATUS_OFS) begin
         prdata[7:0]   = relays_ff;
         prdata[11:8]  = s_stage.trip;
         prdata[15:12] = s_stage.start;
         prdata[17:16] = recorder_led_ff;
         prdata[18]    = self_fault_alarm_ff;
         prdata[19]    = self_fault_led_ff;
         prdata[20]    = supply_indicator_ff;
      end else if (paddr == psr_pkg::DISP_OFS) begin
         prdata[2:0] = display_index_ff;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Blocking and routing
   ////////////////////////////////////////////////////////////////////////////
   logic [3:0] eff_trip;
   psr_pkg::psr_out_t nxt_relays;

   // Blocked trips vanish before relays and indicators see them
   always_comb begin
      eff_trip = s_stage.trip;
      if (s_block && res_option_ff[3]) begin
         eff_trip[psr_pkg::STG_RL] = 1'b0;
      end
      if (s_block && res_option_ff[4]) begin
         eff_trip[psr_pkg::STG_RH] = 1'b0;
      end
      if (s_block && uv_option_ff[4]) begin
         eff_trip[psr_pkg::STG_UV] = 1'b0;
      end
   end

   // OR of fixed and switch-enabled sources; indicator latches not involved
   always_comb begin
      nxt_relays = '0;
      nxt_relays.trip_relay = |(eff_trip & route_switch_ff[3:0]);
      nxt_relays.shared_alarm =
         (eff_trip[psr_pkg::STG_OV] & route_switch_ff[4]) |
         (eff_trip[psr_pkg::STG_UV] & route_switch_ff[5]) |
         (s_stage.start[psr_pkg::STG_OV] & route_switch_ff[6]);
      nxt_relays.uv_alarm = s_stage.start[psr_pkg::STG_UV] & route_switch_ff[7];
      nxt_relays.ov_alarm  = eff_trip[psr_pkg::STG_OV];
      nxt_relays.res_alarm = eff_trip[psr_pkg::STG_RL];
      nxt_relays.recorder_trigger_one =
         (s_stage.start[psr_pkg::STG_OV] & uv_option_ff[0]) |
         (s_stage.start[psr_pkg::STG_UV] & uv_option_ff[1]);
      nxt_relays.recorder_trigger_two =
         (s_stage.start[psr_pkg::STG_RL] & res_option_ff[0]) |
         (s_stage.start[psr_pkg::STG_RH] & res_option_ff[1]);
      nxt_relays.recorder_trigger_three =
         (s_stage.start[psr_pkg::STG_UV] & uv_option_ff[2]) |
         (s_stage.start[psr_pkg::STG_RH] & res_option_ff[2]);
   end

   // Registered relay drive
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         relays_ff <= '0;
      end else begin
         relays_ff <= nxt_relays;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Stage indicators
   ////////////////////////////////////////////////////////////////////////////
   logic clear_req;

   assign clear_req = s_rst_btn || sw_clear;

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_led
         psr_stage_led u_led (
            .pclk        (pclk),
            .presetn     (presetn),
            .start       (s_stage.start[gi]),
            .trip        (eff_trip[gi]),
            .manual_mode (manual_mode_ff[gi]),
            .clear       (clear_req),
            .led         (stage_led[gi])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Recorder indicator, supervision, display
   ////////////////////////////////////////////////////////////////////////////
   psr_pkg::psr_led_t nxt_recorder_led;

   // Green while recording wins; red as long as memory holds data
   always_comb begin
      if (s_rec_act) begin
         nxt_recorder_led = psr_pkg::PSR_LED_GREEN;
      end else if (s_rec_stored) begin
         nxt_recorder_led = psr_pkg::PSR_LED_RED;
      end else begin
         nxt_recorder_led = psr_pkg::PSR_LED_DARK;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         recorder_led_ff <= psr_pkg::PSR_LED_DARK;
      end else begin
         recorder_led_ff <= nxt_recorder_led;
      end
   end

   // Supervision outputs; the 25 % comparison is done by the analog monitor
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         self_fault_alarm_ff <= 1'b0;
         self_fault_led_ff   <= 1'b0;
         supply_indicator_ff <= 1'b0;
      end else begin
         self_fault_alarm_ff <= s_dev || s_absent || s_aux_lost;
         self_fault_led_ff   <= s_perm;
         supply_indicator_ff <= s_supply;
      end
   end

   // Scroll press edge; held button counts once
   logic scroll_d_ff;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scroll_d_ff      <= 1'b0;
         display_index_ff <= '0;
      end else begin
         scroll_d_ff <= s_scroll;
         if (s_scroll && !scroll_d_ff) begin
            display_index_ff <= display_index_ff + 3'd1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Assertions
   ////////////////////////////////////////////////////////////////////////////
   a_trip_relay_ov: assert property (@(posedge pclk) disable iff (!presetn)
      (eff_trip[psr_pkg::STG_OV] && route_switch_ff[0]) |=> relays_ff.trip_relay)
      else $error("OV trip not on trip relay");

   a_shared_uv_trip: assert property (@(posedge pclk) disable iff (!presetn)
      (eff_trip[psr_pkg::STG_UV] && route_switch_ff[5]) |=> relays_ff.shared_alarm)
      else $error("UV trip not on shared alarm");

   a_shared_ov_start: assert property (@(posedge pclk) disable iff (!presetn)
      (s_stage.start[psr_pkg::STG_OV] && route_switch_ff[6]) |=> relays_ff.shared_alarm)
      else $error("OV start not on shared alarm");

   a_uv_alarm_map: assert property (@(posedge pclk) disable iff (!presetn)
      relays_ff.uv_alarm == $past(s_stage.start[psr_pkg::STG_UV] & route_switch_ff[7]))
      else $error("UV alarm mismatch");

   a_fixed_alarms: assert property (@(posedge pclk) disable iff (!presetn)
      relays_ff.res_alarm == $past(eff_trip[psr_pkg::STG_RL]) &&
      relays_ff.ov_alarm == $past(eff_trip[psr_pkg::STG_OV]))
      else $error("residual alarm mismatch");

   a_trig_two_map: assert property (@(posedge pclk) disable iff (!presetn)
      (s_stage.start[psr_pkg::STG_RH] && res_option_ff[1]) |=> relays_ff.recorder_trigger_two)
      else $error("trigger two missing");

   a_block_res_low: assert property (@(posedge pclk) disable iff (!presetn)
      (s_block && res_option_ff[3]) |-> !eff_trip[psr_pkg::STG_RL])
      else $error("residual low trip not blocked");

   a_trig_three_uv: assert property (@(posedge pclk) disable iff (!presetn)
      (s_stage.start[psr_pkg::STG_UV] && uv_option_ff[2]) |=> relays_ff.recorder_trigger_three)
      else $error("trigger three missing");

   a_block_uv: assert property (@(posedge pclk) disable iff (!presetn)
      (s_block && uv_option_ff[4] && !eff_trip[psr_pkg::STG_OV] && !eff_trip[psr_pkg::STG_RL] &&
       !eff_trip[psr_pkg::STG_RH]) |=> !relays_ff.trip_relay)
      else $error("UV block leaked");

   a_rec_red: assert property (@(posedge pclk) disable iff (!presetn)
      (s_rec_stored && !s_rec_act) |=> recorder_led_ff == psr_pkg::PSR_LED_RED)
      else $error("recorder not red");

   a_self_alarm: assert property (@(posedge pclk) disable iff (!presetn)
      s_absent |=> self_fault_alarm_ff)
      else $error("self fault alarm missing");

endmodule : psr_top

/* design/psr_pkg.sv */
// Package: constants and carrier structs for the protection signal routing block
package psr_pkg;

   // APB register byte offsets
   localparam logic [7:0] ROUTE_SW_OFS  = 8'h00;
   localparam logic [7:0] UV_OPT_OFS    = 8'h04;
   localparam logic [7:0] RES_OPT_OFS   = 8'h08;
   localparam logic [7:0] CTRL_OFS      = 8'h0C;
   localparam logic [7:0] STATUS_OFS    = 8'h10;
   localparam logic [7:0] DISP_OFS      = 8'h14;

   // Reset values of the switch groups (bit0 = switch 1)
   localparam logic [7:0] ROUTE_SW_RST  = 8'hFF;
   localparam logic [7:0] UV_OPT_RST    = 8'h15;
   localparam logic [7:0] RES_OPT_RST   = 8'h01;
   localparam logic [3:0] CTRL_RST      = 4'hF;

   // Display index wrap
   localparam int         DISP_STEPS    = 8;
   localparam int         SYNC_STAGES   = 2;

   // Stage order used across the block
   localparam int         STG_OV        = 0;
   localparam int         STG_UV        = 1;
   localparam int         STG_RL        = 2;
   localparam int         STG_RH        = 3;

   // Indicator colour encoding
   typedef enum logic [1:0] {
      PSR_LED_DARK   = 2'b00,
      PSR_LED_YELLOW = 2'b01,
      PSR_LED_RED    = 2'b11,
      PSR_LED_GREEN  = 2'b10
   } psr_led_t;

   // Raw inputs from the protection stages
   typedef struct packed {
      logic [3:0] start;
      logic [3:0] trip;
   } psr_stage_t;

   // Output relays and recorder triggers
   typedef struct packed {
      logic trip_relay;
      logic shared_alarm;
      logic ov_alarm;
      logic uv_alarm;
      logic res_alarm;
      logic recorder_trigger_one;
      logic recorder_trigger_two;
      logic recorder_trigger_three;
   } psr_out_t;

endpackage : psr_pkg

/* design/psr_stage_led.sv */
// One stage operation indicator with optional trip latch
`timescale 1ns/10ps
module psr_stage_led (
   input  wire logic          pclk,
   input  wire logic          presetn,
   input  wire logic          start,
   input  wire logic          trip,
   input  wire logic          manual_mode,
   input  wire logic          clear,
   output psr_pkg::psr_led_t  led
);

   logic latch_ff;

   // Set beats clear so a trip in the clear cycle is not lost
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         latch_ff <= 1'b0;
      end else if (trip && manual_mode) begin
         latch_ff <= 1'b1;
      end else if (clear || !manual_mode) begin
         latch_ff <= 1'b0;
      end
   end

   // Red outranks yellow
   always_comb begin
      if (trip || latch_ff) begin
         led = psr_pkg::PSR_LED_RED;
      end else if (start) begin
         led = psr_pkg::PSR_LED_YELLOW;
      end else begin
         led = psr_pkg::PSR_LED_DARK;
      end
   end

   a_latch_holds: assert property (@(posedge pclk) disable iff (!presetn)
      (manual_mode && trip) |=> (led == psr_pkg::PSR_LED_RED))
      else $error("latched trip not red");

endmodule : psr_stage_led

/* tb/psr_rec_model.sv */
// Behavioural disturbance recorder fed by the block's recorder trigger outputs
`timescale 1ns/10ps
module psr_rec_model #(
   parameter int REC_LEN = 24
) (
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire psr_pkg::psr_out_t relays,
   input  wire logic              erase,
   output logic                   rec_active_ff,
   output logic                   rec_stored_ff,
   output int                     steady_ff
);
   logic [2:0] trig;
   logic [2:0] trig_prev_ff;
   logic [1:0] state_prev_ff;
   int         left_ff;

   assign trig = {relays.recorder_trigger_one, relays.recorder_trigger_two, relays.recorder_trigger_three};

   ////////////////////////////////////////////////////////////////////////////////
   // A fresh trigger edge starts a fixed take; stored data stays until erased
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trig_prev_ff  <= '0;
         rec_active_ff <= 1'b0;
         rec_stored_ff <= 1'b0;
         left_ff       <= 0;
      end else begin
         trig_prev_ff <= trig;
         if (rec_active_ff) begin
            left_ff <= left_ff - 1;
            if (left_ff == 1) begin
               rec_active_ff <= 1'b0;
               rec_stored_ff <= 1'b1;
            end
         end else if (|(trig & ~trig_prev_ff)) begin
            rec_active_ff <= 1'b1;
            left_ff       <= REC_LEN;
         end else if (erase) begin
            rec_stored_ff <= 1'b0;
         end
      end
   end

   // Cycles since the last change, so the bench only judges a settled indicator
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_prev_ff <= '0;
         steady_ff     <= 0;
      end else begin
         state_prev_ff <= {rec_active_ff, rec_stored_ff};
         if ({rec_active_ff, rec_stored_ff} != state_prev_ff) begin
            steady_ff <= 0;
         end else if (steady_ff < 1000) begin
            steady_ff <= steady_ff + 1;
         end
      end
   end
endmodule : psr_rec_model

/* tb/test_protection_signal_routing.sv */
// Self-checking bench for the protection signal routing block
`timescale 1ns/10ps
module test_protection_signal_routing;
   localparam int LIMIT = 10000;
   logic                pclk = 1'b0;
   logic                presetn;
   logic [7:0]          paddr;
   logic                psel;
   logic                penable;
   logic                pwrite;
   logic [31:0]         pwdata;
   logic [31:0]         prdata;
   logic                pready;
   logic                pslverr;
   psr_pkg::psr_stage_t stage_in;
   logic                blk;
   logic                btn;
   logic                scroll;
   logic [4:0]          sup;      // Deviation, absent, aux lost, permanent fault, supply ok
   logic                erase;
   logic                rec_act;
   logic                rec_sto;
   int                  steady;
   psr_pkg::psr_out_t   relays;
   psr_pkg::psr_led_t   sled [4];
   psr_pkg::psr_led_t   rled;
   logic                alarm;
   logic                fled;
   logic                supled;
   logic [2:0]          disp;
   int                  failures = 0;
   int                  checks_done = 0;
   int                  cyc = 0;
   int                  dcount = 0;
   logic                scroll_prev = 1'b0;
   logic [31:0]         rnd = 32'h0000_b1e3;
   logic [7:0]          route;
   logic [7:0]          uvo;
   logic [7:0]          reso;
   logic [3:0]          mode;
   logic [3:0]          lat;
   logic [3:0]          te;
   logic [31:0]         rd;
   logic                er;

   psr_top i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .stage_in(stage_in), .external_block_input(blk), .reset_button(btn), .scroll_button(scroll),
      .recording_active(rec_act), .recording_stored(rec_sto), .supply_deviation(sup[4]),
      .supply_absent(sup[3]), .aux_input_lost(sup[2]), .permanent_fault(sup[1]), .supply_ok(sup[0]),
      .relays_ff(relays), .stage_led(sled), .recorder_led_ff(rled), .self_fault_alarm_ff(alarm),
      .self_fault_led_ff(fled), .supply_indicator_ff(supled), .display_index_ff(disp));

   psr_rec_model i_rec (.pclk(pclk), .presetn(presetn), .relays(relays), .erase(erase),
      .rec_active_ff(rec_act), .rec_stored_ff(rec_sto), .steady_ff(steady));

   ////////////////////////////////////////////////////////////////////////////////
   // Clock and hang guard
   always #2 pclk = ~pclk;

   always @(posedge pclk) begin
      cyc++;
      if (cyc == LIMIT) begin
         failures++;
         results();
      end
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   task automatic results();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : results

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   // Setup cycle, then access held until pready is seen high at a rising edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rdv, output logic erv);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      paddr   <= a;
      pwrite  <= wr;
      pwdata  <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rdv = prdata;
      erv = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   ////////////////////////////////////////////////////////////////////////////////
   // Reference model: blocking first, then fixed wiring OR enabled switches
   function automatic logic [3:0] eff_trip();
      return stage_in.trip & ~({reso[4], reso[3], uvo[4], 1'b0} & {4{blk}});
   endfunction : eff_trip

   function automatic logic [7:0] exp_out(input logic [3:0] st, input logic [3:0] t);
      return {|(route[3:0] & t), route[4] & t[0] | route[5] & t[1] | route[6] & st[0], t[0],
              route[7] & st[1], t[2], uvo[0] & st[0] | uvo[1] & st[1],
              reso[0] & st[2] | reso[1] & st[3], reso[2] & st[3] | uvo[2] & st[1]};
   endfunction : exp_out

   function automatic logic [1:0] led_exp(input int i);
      if (te[i] | lat[i]) return psr_pkg::PSR_LED_RED;
      if (stage_in.start[i]) return psr_pkg::PSR_LED_YELLOW;
      return psr_pkg::PSR_LED_DARK;
   endfunction : led_exp

   // New switch settings; the clear pulse leaves only trips still present latched
   task automatic setup_regs(input logic [31:0] r);
      route = r[7:0];
      uvo   = r[15:8];
      reso  = r[23:16];
      mode  = r[27:24];
      apb(1'b1, psr_pkg::ROUTE_SW_OFS, {24'h0, route}, rd, er);
      apb(1'b1, psr_pkg::UV_OPT_OFS, {24'h0, uvo}, rd, er);
      apb(1'b1, psr_pkg::RES_OPT_OFS, {24'h0, reso}, rd, er);
      apb(1'b1, psr_pkg::CTRL_OFS, {23'h0, 1'b1, 4'h0, mode}, rd, er);
      te  = eff_trip();
      lat = mode & te;
   endtask : setup_regs

   task automatic check_all();
      for (int i = 0; i < 4; i++) chk("stage_led", {30'h0, led_exp(i)}, {30'h0, sled[i]});
      chk("relays", {24'h0, exp_out(stage_in.start, te)}, {24'h0, relays});
      if (steady >= 5) chk("recorder_led", {30'h0, rec_act ? psr_pkg::PSR_LED_GREEN : rec_sto ?
         psr_pkg::PSR_LED_RED : psr_pkg::PSR_LED_DARK}, {30'h0, rled});
      chk("self_fault_alarm", {31'h0, |sup[4:2]}, {31'h0, alarm});
      chk("self_fault_led", {31'h0, sup[1]}, {31'h0, fled});
      chk("supply_indicator", {31'h0, sup[0]}, {31'h0, supled});
      chk("display_index", dcount, {29'h0, disp});
      apb(1'b0, psr_pkg::STATUS_OFS, 32'h0, rd, er);
      chk("status", {11'h0, sup[0], sup[1], |sup[4:2], 10'h0, exp_out(stage_in.start, te)},
          rd & 32'h001c_00ff);
   endtask : check_all

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      presetn  = 1'b0;
      psel     = 1'b0;
      penable  = 1'b0;
      paddr    = 8'h00;
      pwrite   = 1'b0;
      pwdata   = 32'h0000_0000;
      stage_in = '0;
      {blk, btn, scroll, erase} = 4'h0;
      sup      = 5'h00;
      route    = psr_pkg::ROUTE_SW_RST;
      uvo      = psr_pkg::UV_OPT_RST;
      reso     = psr_pkg::RES_OPT_RST;
      mode     = psr_pkg::CTRL_RST;
      lat      = 4'h0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, psr_pkg::ROUTE_SW_OFS, 32'h0, rd, er);
      chk("route_switch", {24'h0, route}, rd & 32'h0000_00ff);
      apb(1'b0, psr_pkg::UV_OPT_OFS, 32'h0, rd, er);
      chk("uv_option", {24'h0, uvo}, rd & 32'h0000_00ff);
      apb(1'b0, psr_pkg::RES_OPT_OFS, 32'h0, rd, er);
      chk("res_option", {24'h0, reso}, rd & 32'h0000_00ff);
      apb(1'b1, 8'h18, 32'hffff_ffff, rd, er);
      chk("pslverr", 32'h0000_0001, {31'h0, er});
      apb(1'b0, 8'h18, 32'h0, rd, er);
      chk("unmapped_read", 32'h0000_0000, rd);
      apb(1'b1, psr_pkg::STATUS_OFS, 32'hffff_ffff, rd, er);
      for (int n = 0; n < 240; n++) begin
         rnd = lfsr(rnd);
         if (n % 24 == 23) setup_regs(rnd);
         rnd = lfsr(rnd);
         @(posedge pclk);
         stage_in <= rnd[7:0];
         blk      <= rnd[8];
         btn      <= (rnd[11:9] == 3'h0);
         scroll   <= rnd[12];
         sup      <= rnd[17:13];
         erase    <= (rnd[20:18] == 3'h0);
         repeat (5) @(posedge pclk);
         #1;
         te  = eff_trip();
         lat = btn ? (mode & te) : (lat | (mode & te));
         if (scroll && !scroll_prev) dcount = (dcount + 1) % psr_pkg::DISP_STEPS;
         scroll_prev = scroll;
         check_all();
      end
      results();
   end
endmodule : test_protection_signal_routing
